/* pkg/sdt_pkg.sv */
// Constants, types and register layout for the dual-mode supervision timer.
package sdt_pkg;
   // Counter width of the down-counter.
   localparam int CNT_W = 16;
   // Base of the signal processor instance, a 16-bit word address in its I/O space.
   localparam logic [31:0] SP_BASE = 32'h0000_3400;
   // Base of the main processor instance, a byte address in its space.
   localparam logic [31:0] MP_BASE = 32'hfffe_c800;
   // Access width codes carried on the bus request.
   localparam logic [1:0] WID_8 = 2'h0;
   localparam logic [1:0] WID_16 = 2'h1;
   localparam logic [1:0] WID_32 = 2'h2;
   // Register indexes; the main instance places index n at byte offset 4n.
   localparam logic [1:0] IDX_COUNT = 2'h0;
   localparam logic [1:0] IDX_CTRL = 2'h1;
   localparam int NUM_REGS = 2;
   // Control register fields.
   localparam int CTRL_MODE_BIT = 0;
   localparam int CTRL_AUTO_BIT = 1;
   localparam int CTRL_RUN_BIT = 2;
   // Values after reset.
   localparam logic [15:0] CNT_RST = 16'hffff;
   localparam logic MODE_RST = 1'h1;
   localparam logic AUTO_RST = 1'h0;
   localparam logic RUN_RST = 1'h0;

   // Counter activity, Gray coded.
   typedef enum logic [1:0] {
      SDT_IDLE = 2'h0,
      SDT_RUN = 2'h1
   } sdt_state_t;

   // One request on the private peripheral bus.
   typedef struct packed {
      logic sel;
      logic write;
      logic ownBus;
      logic [1:0] width;
      logic [31:0] addr;
      logic [15:0] wdata;
   } sdt_req_t;

   // The answer to one request.
   typedef struct packed {
      logic ack;
      logic err;
      logic [15:0] rdata;
   } sdt_rsp_t;
endpackage : sdt_pkg

/* hdl/sdt_supervision_timer.sv */
// Dual-mode supervision timer: watchdog reset generator or general-purpose down-counter.
`timescale 1ns/1ps
// What this block does
// RULE_01: Two modes: supervision reset, or timer interrupt.
// RULE_02: Software rewrites count before underflow in supervision.
// RULE_03: Supervision underflow raises processor reset request.
// RULE_04: Signal processor instance resets only itself.
// RULE_05: Main instance resets both processors.
// RULE_06: Timer down-counter is sixteen bits wide.
// RULE_07: Timer offers auto-reload and one-shot behaviour.
// RULE_08: Count readable while running, undisturbed.
// RULE_09: Timer interrupts when count reaches zero.
// RULE_10: Masters use 16-bit accesses on signal instance.
// RULE_11: Wrong width answers bus error plus interrupt.
// RULE_12: Signal instance decodes word addresses at its base.
// RULE_13: Only own private bus may access registers.
// RULE_14: Main instance decodes 32-bit accesses at base.
// RULE_15: Auto-reload reloads at zero; one-shot stops.
// RULE_16: Count write loads counter next cycle.
module sdt_supervision_timer #(
   parameter bit IS_SIGNAL_PROC = 1'b0 // Selects signal processor instance when set.
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire sdt_pkg::sdt_req_t busReq,
   output sdt_pkg::sdt_rsp_t busRsp,
   output logic busErrIrq,
   output logic timerIrq,
   output logic mainRstReq,
   output logic signalRstReq
);
   // The instance picks its own base and access width once at elaboration.
   localparam logic [31:0] BASE = IS_SIGNAL_PROC ? sdt_pkg::SP_BASE : sdt_pkg::MP_BASE;
   localparam logic [1:0] ACC_W = IS_SIGNAL_PROC ? sdt_pkg::WID_16 : sdt_pkg::WID_32;

   // Turns an address into a register index, one word per index.
   function automatic logic [31:0] regOffset(input logic [31:0] a);
      logic [31:0] off;
      off = a - BASE;
      regOffset = IS_SIGNAL_PROC ? off : {2'h0, off[31:2]}; // RULE_12 RULE_14
   endfunction : regOffset

   // Tells whether an address lands on one of the implemented registers.
   function automatic logic regHit(input logic [31:0] a);
      logic [31:0] off;
      off = a - BASE;
      regHit = (a >= BASE) && (regOffset(a) < 32'(sdt_pkg::NUM_REGS));
      if (!IS_SIGNAL_PROC && off[1:0] != 2'h0) begin
         regHit = 1'b0; // A misaligned byte address never reaches a word.
      end
   endfunction : regHit

   logic [15:0] cnt_reg, cnt_next; // Live down-counter.
   logic [15:0] reload_reg, reload_next; // Last value software wrote to the count.
   logic mode_reg, mode_next; // One selects supervision, zero selects timer.
   logic auto_reg, auto_next; // One selects auto-reload in timer mode.
   logic run_reg, run_next; // Software run enable.
   sdt_pkg::sdt_state_t state_reg, state_next; // Counting or idle.
   sdt_pkg::sdt_rsp_t rsp_reg, rsp_next; // Registered bus answer.
   logic busErr_reg, busErr_next; // Bus error interrupt pulse.
   logic irq_reg, irq_next; // Timer interrupt pulse.
   logic mainRst_reg, mainRst_next; // Reset request to the main processor.
   logic sigRst_reg, sigRst_next; // Reset request to the signal processor.
   logic accept; // Request arrives on our own bus.
   logic good; // Accepted request is mapped and of the right width.
   logic [1:0] idx; // Register index of the request.
   logic [31:0] reqOff; // Full offset of the request in register units; only the low bits select a register.

   // Next-state logic: counting first, then the bus access, whose count write overrides the counting.
   always_comb begin
      cnt_next = cnt_reg;
      reload_next = reload_reg;
      mode_next = mode_reg;
      auto_next = auto_reg;
      run_next = run_reg;
      state_next = state_reg;
      rsp_next = '0;
      busErr_next = 1'b0;
      irq_next = 1'b0;
      mainRst_next = 1'b0;
      sigRst_next = 1'b0;
      accept = busReq.sel && busReq.ownBus; // RULE_13
      good = regHit(busReq.addr) && (busReq.width == ACC_W); // RULE_10
      reqOff = regOffset(busReq.addr);
      idx = reqOff[1:0];
      // Counting runs first so that a same-cycle count write below wins.
      unique case (state_reg)
         sdt_pkg::SDT_IDLE: begin
            cnt_next = cnt_reg; // Held until software restarts it.
         end
         sdt_pkg::SDT_RUN: begin
            if (cnt_reg != 16'h0000) begin
               cnt_next = cnt_reg - 16'h0001; // RULE_06
            end else if (mode_reg) begin
               // Underflow in supervision mode: reset and start again.
               mainRst_next = !IS_SIGNAL_PROC; // RULE_04 RULE_05
               sigRst_next = 1'b1; // RULE_03 RULE_05
               cnt_next = reload_reg;
            end else begin
               irq_next = 1'b1; // RULE_09 RULE_01
               if (auto_reg) begin
                  cnt_next = reload_reg; // RULE_07 RULE_15
               end else begin
                  state_next = sdt_pkg::SDT_IDLE; // RULE_15
               end
            end
         end
      endcase
      // Foreign-bus requests get no answer at all; the block is invisible there.
      if (accept) begin
         if (good) begin
            rsp_next.ack = 1'b1;
            if (busReq.write) begin
               if (idx == sdt_pkg::IDX_COUNT) begin
                  cnt_next = busReq.wdata; // RULE_16 RULE_02
                  reload_next = busReq.wdata;
                  state_next = run_reg ? sdt_pkg::SDT_RUN : sdt_pkg::SDT_IDLE;
               end else begin
                  mode_next = busReq.wdata[sdt_pkg::CTRL_MODE_BIT];
                  auto_next = busReq.wdata[sdt_pkg::CTRL_AUTO_BIT];
                  run_next = busReq.wdata[sdt_pkg::CTRL_RUN_BIT];
                  state_next = busReq.wdata[sdt_pkg::CTRL_RUN_BIT] ? sdt_pkg::SDT_RUN : sdt_pkg::SDT_IDLE;
               end
            end else if (idx == sdt_pkg::IDX_COUNT) begin
               rsp_next.rdata = cnt_reg; // RULE_08
            end else begin
               rsp_next.rdata = {13'h0000, run_reg, auto_reg, mode_reg};
            end
         end else begin
            // Wrong width or unmapped offset: error answer, no register changes.
            rsp_next.err = 1'b1; // RULE_11
            busErr_next = 1'b1; // RULE_11
         end
      end
   end

   // Register stage; every output is one of these flip-flops.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= sdt_pkg::CNT_RST;
         reload_reg <= sdt_pkg::CNT_RST;
         mode_reg <= sdt_pkg::MODE_RST;
         auto_reg <= sdt_pkg::AUTO_RST;
         run_reg <= sdt_pkg::RUN_RST;
         state_reg <= sdt_pkg::SDT_IDLE;
         rsp_reg <= '0;
         busErr_reg <= 1'b0;
         irq_reg <= 1'b0;
         mainRst_reg <= 1'b0;
         sigRst_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         reload_reg <= reload_next;
         mode_reg <= mode_next;
         auto_reg <= auto_next;
         run_reg <= run_next;
         state_reg <= state_next;
         rsp_reg <= rsp_next;
         busErr_reg <= busErr_next;
         irq_reg <= irq_next;
         mainRst_reg <= mainRst_next;
         sigRst_reg <= sigRst_next;
      end
   end

   assign busRsp = rsp_reg;
   assign busErrIrq = busErr_reg;
   assign timerIrq = irq_reg;
   assign mainRstReq = mainRst_reg;
   assign signalRstReq = sigRst_reg;

   // Checks on the counter, its events and the bus answers.
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   a_wdog_underflow_reset: assert property ( // RULE_03
      (state_reg == sdt_pkg::SDT_RUN && mode_reg && cnt_reg == 16'h0000) |=> signalRstReq && !timerIrq)
      else $error("Supervision underflow did not request a reset.");
   a_sig_scope_only: assert property ( // RULE_04
      IS_SIGNAL_PROC |-> !mainRstReq)
      else $error("Signal instance reset the main processor.");
   a_main_scope_both: assert property ( // RULE_05
      !IS_SIGNAL_PROC && signalRstReq |-> mainRstReq)
      else $error("Main instance reset did not reach both processors.");
   a_timer_zero_irq: assert property ( // RULE_09
      (state_reg == sdt_pkg::SDT_RUN && !mode_reg && cnt_reg == 16'h0000) |=> timerIrq && !signalRstReq)
      else $error("Timer reached zero without an interrupt.");
   a_timer_never_resets: assert property ( // RULE_01
      !$past(mode_reg) |-> !signalRstReq && !mainRstReq)
      else $error("Timer mode raised a reset.");
   a_count_decrements: assert property ( // RULE_06
      (state_reg == sdt_pkg::SDT_RUN && cnt_reg != 16'h0000 && !busReq.sel) |=> cnt_reg == $past(cnt_reg) - 16'h0001)
      else $error("Counter did not step down by one.");
   a_oneshot_stops: assert property ( // RULE_15
      (state_reg == sdt_pkg::SDT_RUN && !mode_reg && !auto_reg && cnt_reg == 16'h0000 && !busReq.sel)
      |=> state_reg == sdt_pkg::SDT_IDLE ##1 (cnt_reg == 16'h0000 || $past(busReq.sel)))
      else $error("One-shot counter did not stop at zero.");
   a_auto_reloads: assert property ( // RULE_07
      (state_reg == sdt_pkg::SDT_RUN && !mode_reg && auto_reg && cnt_reg == 16'h0000 && !busReq.sel)
      |=> cnt_reg == reload_reg && state_reg == sdt_pkg::SDT_RUN)
      else $error("Auto-reload counter did not reload.");
   a_count_write_loads: assert property ( // RULE_16
      (busReq.sel && busReq.ownBus && busReq.write && regHit(busReq.addr) && busReq.width == ACC_W
       && idx == sdt_pkg::IDX_COUNT) |=> cnt_reg == $past(busReq.wdata) && busRsp.ack)
      else $error("Count write did not load the counter.");
   a_read_live_count: assert property ( // RULE_08
      (busReq.sel && busReq.ownBus && !busReq.write && regHit(busReq.addr) && busReq.width == ACC_W
       && idx == sdt_pkg::IDX_COUNT) |=> busRsp.rdata == $past(cnt_reg))
      else $error("Count read did not return the live value.");
   a_bad_width_error: assert property ( // RULE_11
      (busReq.sel && busReq.ownBus && busReq.width != ACC_W) |=> busRsp.err && busErrIrq && !busRsp.ack)
      else $error("Wrong-width access was not refused.");
   a_foreign_ignored: assert property ( // RULE_13
      (busReq.sel && !busReq.ownBus) |=> !busRsp.ack && !busRsp.err)
      else $error("Foreign bus request was answered.");

   c_wdog_fires: cover property (signalRstReq);
   c_timer_fires: cover property (timerIrq ##[1:40] timerIrq);
   c_bus_error: cover property (busErrIrq);
   c_oneshot_done: cover property (timerIrq && !auto_reg ##1 state_reg == sdt_pkg::SDT_IDLE);
endmodule : sdt_supervision_timer

/* tb/sdt_host_model.sv */
// Bus master model of the owning processor on its private peripheral bus.
`timescale 1ns/1ps
module sdt_host_model (
   input wire logic sys_clk,
   output sdt_pkg::sdt_req_t busReq,
   output logic tgt
);
   // The bus starts idle, so nothing can be taken while reset is low.
   initial begin
      busReq = '0;
      tgt = 1'b0;
   end
   // Presents one request just after an edge; the next edge takes it.
   task automatic op(input logic t, input logic wr, input logic own, input logic [1:0] wid,
         input logic [31:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      #1;
      tgt = t;
      busReq = '{sel: 1'b1, write: wr, ownBus: own, width: wid, addr: a, wdata: d};
   endtask : op
   // Lets the edge that takes the last request pass, then releases the bus.
   // Address and data flip, so a stale value never looks live.
   task automatic idle();
      @(posedge sys_clk);
      #1;
      busReq = '{1'b0, 1'b0, 1'b0, busReq.width, ~busReq.addr, ~busReq.wdata};
   endtask : idle
endmodule : sdt_host_model

/* tb/testbench.sv */
// Self-checking bench for the main and signal processor instances of the timer.
`timescale 1ns/1ps
module testbench;
   localparam logic [5:0] ACK = 6'h20; // Ack alone.
   localparam logic [5:0] ERR = 6'h18; // Error answer with its interrupt.
   localparam logic [5:0] TIM = 6'h04; // Timer interrupt.
   logic sys_clk;
   logic rst_n;
   logic tgt; // 0 steers the host to the main instance, 1 to the signal one.
   sdt_pkg::sdt_req_t req;
   sdt_pkg::sdt_req_t reqM;
   sdt_pkg::sdt_req_t reqS;
   sdt_pkg::sdt_rsp_t rspM;
   sdt_pkg::sdt_rsp_t rspS;
   wire [3:0] irqM; // Bus error, timer, main reset and signal reset of each instance.
   wire [3:0] irqS;
   wire [63:0] obs; // Time, read data and every event output, seen each cycle.
   int cyc = 0;
   int fail_count = 0;
   int samples_checked = 0;
   int seed = 32'ha236;
   logic [63:0] expQ[$]; // Expected observations, oldest first.
   sdt_host_model host (.sys_clk(sys_clk), .busReq(req), .tgt(tgt));
   sdt_supervision_timer #(.IS_SIGNAL_PROC(1'b0)) dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .busReq(reqM),
      .busRsp(rspM), .busErrIrq(irqM[3]), .timerIrq(irqM[2]), .mainRstReq(irqM[1]), .signalRstReq(irqM[0]));
   sdt_supervision_timer #(.IS_SIGNAL_PROC(1'b1)) dut_s (.sys_clk(sys_clk), .rst_n(rst_n), .busReq(reqS),
      .busRsp(rspS), .busErrIrq(irqS[3]), .timerIrq(irqS[2]), .mainRstReq(irqS[1]), .signalRstReq(irqS[0]));
   assign obs = {cyc, rspM.rdata | rspS.rdata, rspM.ack, rspM.err, irqM, rspS.ack, rspS.err, irqS, 4'h0};
   // Only the chosen instance sees a valid request; the other sees the bus idle.
   always_comb begin
      reqM = req;
      reqS = req;
      reqM.sel = req.sel & ~tgt;
      reqS.sel = req.sel & tgt;
   end
   // Clock at 50 ns.
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   // Edge counter used to stamp every expectation with its exact cycle.
   always @(posedge sys_clk) cyc <= cyc + 1;
   // Any event output pops the oldest note; an event with no note is a mismatch.
   always @(negedge sys_clk) begin
      if (obs[15:4] !== 12'h000) begin
         check(obs, expQ.size() > 0 ? expQ.pop_front() : 64'h0);
      end
   end
   // Compares one observation and counts it.
   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("FAIL at %0t: saw %h, expected %h", $time, got, exp);
      end
   endtask : check
   // Prints the counts and the verdict, then stops.
   task automatic end_sim();
      $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_sim
   function automatic logic [63:0] note(input int when, input logic t, input logic [5:0] ev, input logic [15:0] rd);
      note = {when, rd, t ? 6'h00 : ev, t ? ev : 6'h00, 4'h0};
   endfunction : note
   // Word address for the signal instance, byte address for the main one.
   function automatic logic [31:0] ad(input logic t, input logic [1:0] idx);
      ad = t ? sdt_pkg::SP_BASE + {30'h0, idx} : sdt_pkg::MP_BASE + {28'h0, idx, 2'h0};
   endfunction : ad
   function automatic logic [1:0] w(input logic t);
      w = t ? sdt_pkg::WID_16 : sdt_pkg::WID_32;
   endfunction : w
   // One own-bus access; the next edge takes it and its answer shows in the cycle after that edge.
   task automatic acc(input logic t, input logic wr, input logic [1:0] idx, input logic [15:0] d,
         input logic [5:0] ev, input logic [15:0] rd, input logic [1:0] wid);
      host.op(t, wr, 1'b1, wid, ad(t, idx), d);
      expQ.push_back(note(cyc + 1, t, ev, rd));
   endtask : acc
   // Waits until the edge counter reaches a given value.
   task automatic waitc(input int e);
      while (cyc < e) begin
         @(posedge sys_clk);
         #1;
      end
   endtask : waitc
   // Watchdog: the whole run needs well under 2000 cycles.
   initial begin
      #100000;
      fail_count++;
      end_sim();
   end
   // Main sequence, run once against each instance.
   initial begin
      int v;
      int c;
      logic t;
      rst_n = 1'b0;
      repeat (5) @(posedge sys_clk);
      #1 rst_n = 1'b1;
      for (int i = 0; i < 2; i++) begin
         t = i[0];
         v = 4 + ($unsigned($random(seed)) % 16);
         // A foreign write must be ignored, so the reset count survives it.
         host.op(t, 1'b1, 1'b0, w(t), ad(t, 2'h0), 16'($random(seed)));
         acc(t, 1'b0, sdt_pkg::IDX_COUNT, 16'h0, ACK, sdt_pkg::CNT_RST, w(t));
         acc(t, 1'b0, sdt_pkg::IDX_CTRL, 16'h0, ACK, {13'h0, sdt_pkg::RUN_RST, sdt_pkg::AUTO_RST, sdt_pkg::MODE_RST}, w(t));
         acc(t, 1'b0, 2'h2, 16'h0, ERR, 16'h0, w(t));
         acc(t, 1'b1, sdt_pkg::IDX_COUNT, 16'h0, ERR, 16'h0, sdt_pkg::WID_8);
         // Supervision: refreshed three times back to back, then left to underflow twice.
         acc(t, 1'b1, sdt_pkg::IDX_COUNT, 16'(v), ACK, 16'h0, w(t));
         acc(t, 1'b1, sdt_pkg::IDX_CTRL, 16'h0005, ACK, 16'h0, w(t));
         repeat (3) acc(t, 1'b1, sdt_pkg::IDX_COUNT, 16'(v), ACK, 16'h0, w(t));
         c = cyc;
         expQ.push_back(note(c + v + 2, t, t ? 6'h01 : 6'h03, 16'h0));
         expQ.push_back(note(c + 2 * v + 3, t, t ? 6'h01 : 6'h03, 16'h0));
         // The bus must go quiet, or the last refresh would be taken again every cycle.
         host.idle();
         waitc(c + 2 * v + 3);
         acc(t, 1'b1, sdt_pkg::IDX_CTRL, 16'h0001, ACK, 16'h0, w(t));
         // Auto-reload timer, read on the fly just after it starts.
         acc(t, 1'b1, sdt_pkg::IDX_COUNT, 16'(v), ACK, 16'h0, w(t));
         acc(t, 1'b1, sdt_pkg::IDX_CTRL, 16'h0006, ACK, 16'h0, w(t));
         c = cyc;
         acc(t, 1'b0, sdt_pkg::IDX_COUNT, 16'h0, ACK, 16'(v), w(t));
         expQ.push_back(note(c + v + 2, t, TIM, 16'h0));
         expQ.push_back(note(c + 2 * v + 3, t, TIM, 16'h0));
         host.idle();
         waitc(c + 2 * v + 3);
         acc(t, 1'b1, sdt_pkg::IDX_CTRL, 16'h0002, ACK, 16'h0, w(t));
         // One-shot: a single interrupt, then the count rests at zero.
         acc(t, 1'b1, sdt_pkg::IDX_COUNT, 16'(v), ACK, 16'h0, w(t));
         acc(t, 1'b1, sdt_pkg::IDX_CTRL, 16'h0004, ACK, 16'h0, w(t));
         c = cyc;
         expQ.push_back(note(c + v + 2, t, TIM, 16'h0));
         host.idle();
         waitc(c + 3 * v);
         acc(t, 1'b0, sdt_pkg::IDX_COUNT, 16'h0, ACK, 16'h0, w(t));
      end
      host.idle();
      repeat (5) @(posedge sys_clk);
      check(64'(expQ.size()), 64'h0);
      end_sim();
   end
endmodule : testbench
